// ==== uart_ctl_defs.svh ====
/*
 * Register offsets, field positions, reset values and fixed levels for the
 * UART trigger, flow-threshold and RS-485 direction control block.
 * Assumes inclusion by bare name from the design file and the bench.
 */
// Contract
// RQ1: Receive trigger level compares against fill level, drives DMA and interrupt requests.
// RQ2: Trigger field 0x00 and 0x01 mean one byte, others literal, 0x80 128.
// RQ3: High flow threshold held, decoded with zero as one byte.
// RQ4: Low flow threshold held, same decoding, governs resume of remote sender.
// RQ5: Programmable levels apply only in 128-byte mode; 32-byte mode uses fixed levels.
// RQ6: Prescaler value in low four bits, reset zero, upper bits reserved.
// RQ7: In multidrop mode count down turn-around value after last bit leaves.
// RQ8: At countdown zero drive direction pin to receive level.
// RQ9: Turn-around counted in bit periods at programmed baud rate.
// RQ10: Polarity bit 5 picks direction levels: clear gives 0 transmit, 1 receive.
// RQ11: Bit 4 decides whether transmitter drives direction pin at all.
// RQ12: Bit 3 selects request-to-send pin when clear, terminal-ready pin when set.
// RQ13: Bit 2 set disables transmitter.
// RQ14: Bit 1 set disables receiver.
// RQ15: Bit 0 set enables multidrop mode, clear means normal UART.
// RQ16: Hard and software reset clear all six registers to zero.
// RQ17: Pause remote sender at high threshold, resume at low threshold.
// RQ18: With bit 4 set, hold transmit level for whole transmission before countdown.
`ifndef UART_CTL_DEFS_SVH
`define UART_CTL_DEFS_SVH

`define OFS_RX_TRIG      12'h000
`define OFS_FLOW_HIGH    12'h004
`define OFS_FLOW_LOW     12'h008
`define OFS_PRESCALE     12'h00c
`define OFS_TURNAROUND   12'h010
`define OFS_ADV_CTRL2    12'h014
`define OFS_STATUS       12'h018
`define OFS_SW_RESET     12'h01c

`define RST_BYTE         8'h00
`define PRESCALE_MASK    8'h0f
`define ADV_CTRL2_MASK   8'h3f
`define ONE_BYTE         8'h01

`define BIT_MULTIDROP    0
`define BIT_RX_OFF       1
`define BIT_TX_OFF       2
`define BIT_PIN_SEL      3
`define BIT_TX_DRIVES    4
`define BIT_POL_INV      5
`define BIT_SW_RESET     0

`define FIX_TRIG_32      8'h08
`define FIX_HIGH_32      8'h18
`define FIX_LOW_32       8'h08

`endif

// ==== uart_ctl_pkg.sv ====
/*
 * Types shared by the trigger and RS-485 control block.
 * Assumes the defines header is on the include path.
 */
`default_nettype none

package uart_ctl_pkg;
    typedef struct packed {
        logic       direction_polarity_invert;
        logic       transmitter_drives_direction;
        logic       direction_pin_select;
        logic       transmitter_off;
        logic       receiver_off;
        logic       multidrop_enable;
    } adv_ctrl_t;

    typedef struct packed {
        logic       rx_request;
        logic       pause_remote;
        logic       tx_enable;
        logic       rx_enable;
    } ctl_out_t;
endpackage

`default_nettype wire

// ==== uart_trigger_and_rs485_control.sv ====
/*
 * APB register slave holding receive trigger, flow thresholds, prescaler,
 * turn-around delay and second control register, plus the RS-485
 * direction-pin sequencer and flow-control pause logic.
 * Assumes fill level, bit-period tick and transmitter busy/done come from
 * the surrounding UART core, synchronous to clk.
 */
`include "uart_ctl_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module uart_trigger_and_rs485_control
    import uart_ctl_pkg::*;
#(
    parameter int FILL_W = 8
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    // UART core side
    input  wire logic [FILL_W-1:0] rx_fill,
    input  wire logic              fifo_mode_128,
    input  wire logic              bit_tick,
    input  wire logic              tx_busy,
    input  wire logic              tx_last_bit_done,
    // Control outputs
    output ctl_out_t               ctl_out,
    output logic [3:0]             prescale_value,
    // Transceiver direction pins
    output logic                   channel_request_to_send_pins,
    output logic                   channel_terminal_ready_pins
);

    typedef enum logic [1:0] {DIR_RECEIVE, DIR_TRANSMIT, DIR_COUNTDOWN} dir_state_t;

    logic [7:0]  rx_fifo_trigger_level_r;
    logic [7:0]  flow_high_threshold_r;
    logic [7:0]  flow_low_threshold_r;
    logic [7:0]  baud_prescale_r;
    logic [7:0]  turnaround_delay_r;
    logic [7:0]  advanced_control_second_r;
    logic [7:0]  count_r;
    logic        dir_active_r;
    logic        soft_rst_r;
    dir_state_t  state_r;
    adv_ctrl_t   adv;
    logic        wr_en;
    logic        rd_en;
    logic        addr_hit;
    logic [7:0]  trig_eff;
    logic [7:0]  high_eff;
    logic [7:0]  low_eff;
    logic [7:0]  fill8;

    assign adv   = adv_ctrl_t'(advanced_control_second_r[5:0]);
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign fill8 = 8'(rx_fill);

    // Legal register addresses
    always_comb begin
        case (paddr)
            `OFS_RX_TRIG, `OFS_FLOW_HIGH, `OFS_FLOW_LOW, `OFS_PRESCALE,
            `OFS_TURNAROUND, `OFS_ADV_CTRL2, `OFS_STATUS, `OFS_SW_RESET: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    end

    // Zero decodes as one byte
    function automatic logic [7:0] level_decode(input logic [7:0] v);
        level_decode = (v == `RST_BYTE) ? `ONE_BYTE : v; // see RQ2
    endfunction

    // Pick programmable or fixed levels by FIFO mode
    always_comb begin
        if (fifo_mode_128) begin // see RQ5
            trig_eff = level_decode(rx_fifo_trigger_level_r); // see RQ2
            high_eff = level_decode(flow_high_threshold_r); // see RQ3
            low_eff  = level_decode(flow_low_threshold_r); // see RQ4
        end else begin
            trig_eff = `FIX_TRIG_32;
            high_eff = `FIX_HIGH_32;
            low_eff  = `FIX_LOW_32;
        end
    end

    // Software reset strobe, self-clearing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            soft_rst_r <= 1'b0;
        end else begin
            soft_rst_r <= wr_en && addr_hit && (paddr == `OFS_SW_RESET)
                          && pwdata[`BIT_SW_RESET] && !soft_rst_r;
        end
    end

    // Register writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_fifo_trigger_level_r   <= `RST_BYTE;
            flow_high_threshold_r     <= `RST_BYTE;
            flow_low_threshold_r      <= `RST_BYTE;
            baud_prescale_r           <= `RST_BYTE;
            turnaround_delay_r        <= `RST_BYTE;
            advanced_control_second_r <= `RST_BYTE;
        end else if (soft_rst_r) begin // see RQ16
            rx_fifo_trigger_level_r   <= `RST_BYTE;
            flow_high_threshold_r     <= `RST_BYTE;
            flow_low_threshold_r      <= `RST_BYTE;
            baud_prescale_r           <= `RST_BYTE;
            turnaround_delay_r        <= `RST_BYTE;
            advanced_control_second_r <= `RST_BYTE;
        end else if (wr_en) begin
            case (paddr)
                `OFS_RX_TRIG:    rx_fifo_trigger_level_r <= pwdata[7:0]; // see RQ1
                `OFS_FLOW_HIGH:  flow_high_threshold_r   <= pwdata[7:0]; // see RQ3
                `OFS_FLOW_LOW:   flow_low_threshold_r    <= pwdata[7:0]; // see RQ4
                `OFS_PRESCALE:   baud_prescale_r  <= pwdata[7:0] & `PRESCALE_MASK; // see RQ6
                `OFS_TURNAROUND: turnaround_delay_r      <= pwdata[7:0]; // see RQ7
                `OFS_ADV_CTRL2:  advanced_control_second_r <= pwdata[7:0] & `ADV_CTRL2_MASK;
                default: ;
            endcase
        end
    end

    // APB answer: zero wait states, error on unmapped address
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !addr_hit;
        end
    end

    // Read data registered in setup cycle, valid in access phase
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `OFS_RX_TRIG:    prdata <= {24'h000000, rx_fifo_trigger_level_r};
                `OFS_FLOW_HIGH:  prdata <= {24'h000000, flow_high_threshold_r};
                `OFS_FLOW_LOW:   prdata <= {24'h000000, flow_low_threshold_r};
                `OFS_PRESCALE:   prdata <= {24'h000000, baud_prescale_r};
                `OFS_TURNAROUND: prdata <= {24'h000000, turnaround_delay_r};
                `OFS_ADV_CTRL2:  prdata <= {24'h000000, advanced_control_second_r};
                `OFS_STATUS:     prdata <= {24'h000000, count_r[3:0], 1'b0,
                                            dir_active_r, ctl_out.pause_remote,
                                            ctl_out.rx_request};
                default:         prdata <= 32'h0000_0000;
            endcase
        end else if (!rd_en) begin
            prdata <= 32'h0000_0000;
        end
    end

    // Receive request, flow pause with hysteresis, enables; one driver for the struct
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_out.rx_request   <= 1'b0;
            ctl_out.pause_remote <= 1'b0;
            ctl_out.tx_enable    <= 1'b1;
            ctl_out.rx_enable    <= 1'b1;
        end else begin
            ctl_out.tx_enable  <= !adv.transmitter_off; // see RQ13
            ctl_out.rx_enable  <= !adv.receiver_off; // see RQ14
            ctl_out.rx_request <= !adv.receiver_off && (fill8 >= trig_eff); // see RQ1
            if (fill8 >= high_eff) begin
                ctl_out.pause_remote <= 1'b1; // see RQ17
            end else if (fill8 <= low_eff) begin
                ctl_out.pause_remote <= 1'b0; // see RQ17
            end
        end
    end

    // Prescale out
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prescale_value    <= 4'h0;
        end else begin
            prescale_value    <= baud_prescale_r[3:0]; // see RQ6
        end
    end

    // Direction sequencer: transmit, countdown in bit periods, receive
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= DIR_RECEIVE;
            count_r <= `RST_BYTE;
        end else if (!adv.multidrop_enable || soft_rst_r) begin // see RQ15
            state_r <= DIR_RECEIVE;
            count_r <= `RST_BYTE;
        end else begin
            case (state_r)
                DIR_RECEIVE: begin
                    if (tx_busy) begin
                        state_r <= DIR_TRANSMIT; // see RQ18
                    end
                end
                DIR_TRANSMIT: begin
                    if (tx_last_bit_done && !tx_busy) begin
                        state_r <= DIR_COUNTDOWN; // see RQ7
                        count_r <= turnaround_delay_r;
                    end
                end
                DIR_COUNTDOWN: begin
                    if (tx_busy) begin
                        state_r <= DIR_TRANSMIT;
                    end else if (count_r == `RST_BYTE) begin
                        state_r <= DIR_RECEIVE; // see RQ8
                    end else if (bit_tick) begin
                        count_r <= count_r - 8'h01; // see RQ9
                    end
                end
                default: state_r <= DIR_RECEIVE;
            endcase
        end
    end

    // Pin levels from state, polarity and pin select
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dir_active_r                 <= 1'b0;
            channel_request_to_send_pins <= 1'b1;
            channel_terminal_ready_pins  <= 1'b1;
        end else begin
            dir_active_r <= (state_r != DIR_RECEIVE);
            if (adv.multidrop_enable && adv.transmitter_drives_direction) begin // see RQ11
                if (!adv.direction_pin_select) begin // see RQ12
                    channel_request_to_send_pins <= (state_r == DIR_RECEIVE) ^
                                                    adv.direction_polarity_invert; // see RQ10
                    channel_terminal_ready_pins  <= 1'b1;
                end else begin
                    channel_terminal_ready_pins  <= (state_r == DIR_RECEIVE) ^
                                                    adv.direction_polarity_invert; // see RQ10
                    channel_request_to_send_pins <= 1'b1;
                end
            end else begin
                channel_request_to_send_pins <= 1'b1;
                channel_terminal_ready_pins  <= 1'b1;
            end
        end
    end

    // Assertions
    property p_trig_decode;
        @(posedge clk) disable iff (!rst_n)
        (fifo_mode_128 && rx_fifo_trigger_level_r == 8'h00 && fill8 == 8'h01
         && !adv.receiver_off) |=> ctl_out.rx_request;
    endproperty
    a_trig_decode: assert property (p_trig_decode) else $error("zero trigger not one byte"); // see RQ2

    property p_rx_req;
        @(posedge clk) disable iff (!rst_n)
        (!adv.receiver_off && fill8 < trig_eff) |=> !ctl_out.rx_request;
    endproperty
    a_rx_req: assert property (p_rx_req) else $error("rx request below trigger"); // see RQ1

    property p_fixed32;
        @(posedge clk) disable iff (!rst_n)
        (!fifo_mode_128 && !adv.receiver_off && fill8 >= `FIX_TRIG_32) |=> ctl_out.rx_request;
    endproperty
    a_fixed32: assert property (p_fixed32) else $error("32-byte mode level wrong"); // see RQ5

    property p_pause_high;
        @(posedge clk) disable iff (!rst_n)
        (fill8 >= high_eff) |=> ctl_out.pause_remote;
    endproperty
    a_pause_high: assert property (p_pause_high) else $error("no pause at high"); // see RQ17

    property p_prescale;
        @(posedge clk) disable iff (!rst_n)
        baud_prescale_r[7:4] == 4'h0;
    endproperty
    a_prescale: assert property (p_prescale) else $error("prescale reserved bits set"); // see RQ6

    sequence s_countdown_start;
        state_r == DIR_TRANSMIT && tx_last_bit_done && !tx_busy && adv.multidrop_enable
        && !soft_rst_r;
    endsequence

    property p_count_load;
        @(posedge clk) disable iff (!rst_n)
        s_countdown_start |=> (state_r == DIR_COUNTDOWN && count_r == $past(turnaround_delay_r));
    endproperty
    a_count_load: assert property (p_count_load) else $error("countdown not loaded"); // see RQ7

    property p_tick_only;
        @(posedge clk) disable iff (!rst_n)
        (state_r == DIR_COUNTDOWN && $past(state_r) == DIR_COUNTDOWN && !$past(bit_tick))
        |-> $stable(count_r);
    endproperty
    a_tick_only: assert property (p_tick_only) else $error("count moved without tick"); // see RQ9

    property p_rx_level;
        @(posedge clk) disable iff (!rst_n)
        (state_r == DIR_RECEIVE && adv.multidrop_enable && adv.transmitter_drives_direction
         && !adv.direction_pin_select && !adv.direction_polarity_invert)
        |=> channel_request_to_send_pins;
    endproperty
    a_rx_level: assert property (p_rx_level) else $error("receive level wrong"); // see RQ8

    property p_tx_level;
        @(posedge clk) disable iff (!rst_n)
        (state_r == DIR_TRANSMIT && adv.multidrop_enable && adv.transmitter_drives_direction
         && !adv.direction_pin_select)
        |=> (channel_request_to_send_pins == $past(adv.direction_polarity_invert));
    endproperty
    a_tx_level: assert property (p_tx_level) else $error("transmit level wrong"); // see RQ10

    property p_no_drive;
        @(posedge clk) disable iff (!rst_n)
        !adv.transmitter_drives_direction |=> channel_request_to_send_pins
                                              && channel_terminal_ready_pins;
    endproperty
    a_no_drive: assert property (p_no_drive) else $error("pin driven while not allowed"); // see RQ11

    property p_soft_reset;
        @(posedge clk) disable iff (!rst_n)
        soft_rst_r |=> (advanced_control_second_r == 8'h00 && turnaround_delay_r == 8'h00);
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("software reset incomplete"); // see RQ16

endmodule

`default_nettype wire

// ==== uart_core_model.sv ====
/*
 * Far-side model of the UART core: bit-period ticks and a transmit burst.
 * Assumes the bench pulses tx_go for one cycle while no burst is running.
 */
`timescale 1ns/1ps
`default_nettype none

module uart_core_model #(
    parameter int TICK_DIV = 8,
    parameter int NBITS    = 4
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Bench control
    input  wire logic tx_go,
    // Core outputs
    output logic      bit_tick,
    output logic      tx_busy,
    output logic      tx_last_bit_done
);
    int div_r;

    // One tick per bit period at a fixed baud rate
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_r    <= 0;
            bit_tick <= 1'b0;
        end else begin
            div_r    <= (div_r == TICK_DIV - 1) ? 0 : div_r + 1;
            bit_tick <= (div_r == TICK_DIV - 1);
        end
    end

    // Burst: busy for NBITS ticks, then done away from a tick
    initial begin
        tx_busy          = 1'b0;
        tx_last_bit_done = 1'b0;
        forever begin
            @(posedge clk);
            if (tx_go === 1'b1) begin
                tx_busy <= 1'b1;
                repeat (NBITS) begin
                    @(posedge clk);
                    while (bit_tick !== 1'b1) @(posedge clk);
                end
                repeat (2) @(posedge clk);
                tx_busy          <= 1'b0;
                tx_last_bit_done <= 1'b1;
                @(posedge clk);
                tx_last_bit_done <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

// ==== tb_top.sv ====
/*
 * Self-checking bench for the trigger, flow and RS-485 direction block.
 * Assumes the design, its package and header, and the core model.
 */
`timescale 1ns/1ps
`default_nettype none
`include "uart_ctl_defs.svh"
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin fail_count++; \
    $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end

module tb_top;
    import uart_ctl_pkg::*;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0]  rx_fill;
    logic        fifo_mode_128, tx_go, bit_tick, tx_busy, tx_done, rts_pin, dtr_pin;
    ctl_out_t    ctl_out;
    logic [3:0]  prescale_value;
    int          fail_count, total_checks;
    logic [11:0] ofs [6] = '{`OFS_RX_TRIG, `OFS_FLOW_HIGH, `OFS_FLOW_LOW,
                             `OFS_PRESCALE, `OFS_TURNAROUND, `OFS_ADV_CTRL2};

    uart_trigger_and_rs485_control u_dut (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .rx_fill(rx_fill),
        .fifo_mode_128(fifo_mode_128), .bit_tick(bit_tick), .tx_busy(tx_busy),
        .tx_last_bit_done(tx_done), .ctl_out(ctl_out), .prescale_value(prescale_value),
        .channel_request_to_send_pins(rts_pin), .channel_terminal_ready_pins(dtr_pin));
    uart_core_model u_core (.clk(clk), .rst_n(rst_n), .tx_go(tx_go), .bit_tick(bit_tick),
        .tx_busy(tx_busy), .tx_last_bit_done(tx_done));

    // Clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Verdict and end of run
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {24'h0, wd};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) fail_count++;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [7:0] ex);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 8'h00, r, e);
        `CHK("read data", {24'h0, ex}, r)
        `CHK("read error", 1'b0, e)
    endtask

    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic set_fill(input logic [7:0] v);
        @(posedge clk);
        rx_fill <= v;
        settle();
    endtask

    task automatic t_reset();
        for (int i = 0; i < 6; i++) rd_chk(ofs[i], 8'h00);
        `CHK("pins idle", 2'b11, {rts_pin, dtr_pin})
        `CHK("enables", 2'b11, {ctl_out.tx_enable, ctl_out.rx_enable})
        $display("test reset done");
    endtask

    task automatic t_regs();
        logic [31:0] r;
        logic        e;
        wr(`OFS_PRESCALE, 8'hff);
        rd_chk(`OFS_PRESCALE, 8'h0f);
        `CHK("prescale out", 4'hf, prescale_value)
        wr(`OFS_ADV_CTRL2, 8'hff);
        rd_chk(`OFS_ADV_CTRL2, 8'h3f);
        settle();
        `CHK("tx enable", 1'b0, ctl_out.tx_enable)
        `CHK("rx enable", 1'b0, ctl_out.rx_enable)
        wr(`OFS_ADV_CTRL2, 8'h00);
        settle();
        `CHK("enables on", 2'b11, {ctl_out.tx_enable, ctl_out.rx_enable})
        for (int i = 0; i < 5; i++) wr(ofs[i], 8'h81 + 8'(i));
        wr(12'h020, 8'h55);
        for (int i = 0; i < 5; i++) rd_chk(ofs[i], i == 3 ? 8'h04 : 8'h81 + 8'(i));
        apb(1'b0, 12'h020, 8'h00, r, e);
        `CHK("unmapped error", 1'b1, e)
        `CHK("unmapped data", 32'h0, r)
        $display("test registers done");
    endtask

    task automatic t_trigger();
        logic [7:0] trig [4] = '{8'h00, 8'h01, 8'h05, 8'h80};
        logic [7:0] lo   [4] = '{8'h00, 8'h00, 8'h04, 8'h7f};
        @(posedge clk);
        fifo_mode_128 <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr(`OFS_RX_TRIG, trig[i]);
            set_fill(lo[i]);
            `CHK("below trigger", 1'b0, ctl_out.rx_request)
            set_fill(lo[i] + 8'h01);
            `CHK("at trigger", 1'b1, ctl_out.rx_request)
        end
        wr(`OFS_ADV_CTRL2, 8'h02);
        settle();
        `CHK("receiver off", 1'b0, ctl_out.rx_request)
        wr(`OFS_ADV_CTRL2, 8'h00);
        @(posedge clk);
        fifo_mode_128 <= 1'b0;
        set_fill(8'h07);
        `CHK("fixed below", 1'b0, ctl_out.rx_request)
        set_fill(8'h08);
        `CHK("fixed at", 1'b1, ctl_out.rx_request)
        $display("test trigger done");
    endtask

    task automatic t_flow();
        logic [7:0] f [7] = '{8'd0, 8'd15, 8'd16, 8'd10, 8'd5, 8'd4, 8'd10};
        logic       p [7] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
        @(posedge clk);
        fifo_mode_128 <= 1'b1;
        wr(`OFS_FLOW_HIGH, 8'h10);
        wr(`OFS_FLOW_LOW, 8'h04);
        for (int i = 0; i < 7; i++) begin
            set_fill(f[i]);
            `CHK("pause remote", p[i], ctl_out.pause_remote)
            rd_chk(`OFS_STATUS, {6'h00, p[i], 1'b0});
        end
        $display("test flow done");
    endtask

    task automatic send(output int n);
        @(posedge clk);
        tx_go <= 1'b1;
        @(posedge clk);
        tx_go <= 1'b0;
        n = 0;
        while (tx_busy !== 1'b1 && n < 100) begin @(posedge clk); n++; end
        settle();
    endtask

    task automatic t_turnaround();
        logic [7:0] dly [4] = '{8'd0, 8'd3, 8'd1, 8'd5};
        logic       pol, sel, act, oth;
        int         n, k;
        for (int i = 0; i < 4; i++) begin
            pol = i[0];
            sel = i[1];
            wr(`OFS_TURNAROUND, dly[i]);
            wr(`OFS_ADV_CTRL2, {2'b00, pol, 1'b1, sel, 3'b001});
            send(n);
            act = sel ? dtr_pin : rts_pin;
            oth = sel ? rts_pin : dtr_pin;
            `CHK("transmit level", pol, act)
            `CHK("other pin", 1'b1, oth)
            n = 0;
            while (tx_done !== 1'b1 && n < 400) begin @(posedge clk); n++; end
            k = 0;
            while ((sel ? dtr_pin : rts_pin) !== ~pol && n < 800) begin
                @(posedge clk);
                if (bit_tick === 1'b1) k++;
                n++;
            end
            `CHK("ticks counted", int'(dly[i]), k)
            settle();
            `CHK("receive level", ~pol, sel ? dtr_pin : rts_pin)
        end
        $display("test turnaround done");
    endtask

    task automatic t_no_drive();
        logic [7:0] c [2] = '{8'h01, 8'h10};
        int         n;
        for (int i = 0; i < 2; i++) begin
            wr(`OFS_ADV_CTRL2, c[i]);
            send(n);
            `CHK("pins untouched", 2'b11, {rts_pin, dtr_pin})
            while (tx_busy === 1'b1 && n < 400) begin @(posedge clk); n++; end
        end
        $display("test no drive done");
    endtask

    task automatic t_swreset();
        wr(`OFS_SW_RESET, 8'h01);
        for (int i = 0; i < 6; i++) rd_chk(ofs[i], 8'h00);
        `CHK("pins after reset", 2'b11, {rts_pin, dtr_pin})
        $display("test software reset done");
    endtask

    // Main sequence
    initial begin
        rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
        pwdata = 32'h0; rx_fill = 8'h00; fifo_mode_128 = 1'b1; tx_go = 1'b0;
        fail_count = 0; total_checks = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_regs();
        t_trigger();
        t_flow();
        t_turnaround();
        t_no_drive();
        t_swreset();
        summarize();
    end

    // Watchdog
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        summarize();
    end
endmodule

`default_nettype wire
